/* File: ssh_status_top.sv */
`timescale 1ns/100ps
// What this block does
// RL1 - five 16-bit parts per status register
// RL2 - one bit position per status, independent
// RL3 - top bit of every part reads zero
// RL4 - operation bit zero is calibration status
// RL5 - live part follows hardware or sum bits
// RL6 - live part ignores writes, reads harmless
// RL7 - rising edge latches event if enabled
// RL8 - falling edge latches event if enabled
// RL9 - edge filters freely readable and writable
// RL10 - event part read-only, cleared by reading
// RL11 - events come only from filtered edges
// RL12 - masked events OR into sum bit
// RL13 - summary mask freely readable and writable
// RL14 - sum bit feeds next level live bit
// RL15 - sum bits generated automatically, always
// RL16 - status byte tops the hierarchy
// RL17 - request enable masks status byte
// RL18 - message available bit follows output buffer
// RL19 - registers queryable over remote link
// RL20 - enable bit six ignored; six summarises
// RL21 - enabled status bit rising raises request
// RL22 - new event survives simultaneous clearing read
// RL23 - edges found against previous cycle sample
module ssh_status_top (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // remote link register access
  input wire ssh_pkg::ssh_req_s req,
  output ssh_pkg::ssh_rsp_s rsp,
  // hardware status
  input wire logic cal_status,
  input wire logic [14:1] oper_status,
  input wire ssh_pkg::ssh_bits_t ques_status,
  input wire ssh_pkg::ssh_bits_t sev_status,
  input wire logic err_queue_not_empty,
  input wire logic msg_available,
  // status byte and request
  output logic [7:0] status_byte,
  output logic service_request
);
  import ssh_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  ssh_top_s st_q;
  ssh_top_s st_d;
  logic [7:0] stb_live;
  logic [7:0] stb_rise;
  logic mss;

  ssh_bits_t live_vec [NUM_REGS];
  logic [15:0] rdata_vec [NUM_REGS];
  logic [NUM_REGS-1:0] sum_vec;
  logic [NUM_REGS-1:0] wr_vec;
  logic [NUM_REGS-1:0] clr_vec;

  // ****************************************************************
  // status registers
  // ****************************************************************
  // every register shares one layout, so a single loop builds all of
  // them; each bit position is its own lane end to end
  assign live_vec[SEL_OPER] = {oper_status, cal_status}; // RL4
  assign live_vec[SEL_QUES] = ques_status; // RL5
  assign live_vec[SEL_SEV] = sev_status; // RL5

  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      ssh_status_reg u_reg (
        .clock(clock),
        .srst(srst),
        .live_in(live_vec[g]),
        .wr_en(wr_vec[g]),
        .part(req.part),
        .wdata(req.wdata[14:0]),
        .rd_clear(clr_vec[g]),
        .rdata(rdata_vec[g]),
        .sum(sum_vec[g])
      ); // RL1 RL2 RL15
    end
  endgenerate

  // ****************************************************************
  // status byte
  // ****************************************************************
  always_comb begin
    stb_live = 8'h00;
    stb_live[STB_ERR] = err_queue_not_empty;
    stb_live[STB_QUES] = sum_vec[SEL_QUES]; // RL14 RL16
    stb_live[STB_MAV] = msg_available; // RL18
    stb_live[STB_SEV] = sum_vec[SEL_SEV]; // RL14 RL16
    stb_live[STB_OPER] = sum_vec[SEL_OPER]; // RL14 RL16
    // bit six never masks itself, which also avoids a loop
    mss = |(stb_live & st_q.sre & SRE_USED); // RL17 RL20
    stb_live[STB_MSS] = mss; // RL20
    // compare against the byte as registered last cycle
    stb_rise = stb_live & ~st_q.stb & st_q.sre & SRE_USED; // RL21 RL23
  end

  // ****************************************************************
  // request decode
  // ****************************************************************
  // a read returns the part as it stood before this cycle; the clear of
  // an event part lands on the same edge as the captured data, so no
  // event can fall between read and clear
  always_comb begin
    st_d = st_q;
    wr_vec = '0;
    clr_vec = '0;
    st_d.rsp.valid = req.valid; // RL19
    st_d.rsp.data = 16'h0000;
    if (req.valid && req.sel == SEL_STB) begin
      if (req.write && req.part == PART_MASK) begin
        st_d.sre = req.wdata[7:0] & SRE_USED; // RL17 RL20
      end else if (!req.write && req.part == PART_LIVE) begin
        st_d.rsp.data = {8'h00, st_q.stb};
      end else if (!req.write && req.part == PART_MASK) begin
        st_d.rsp.data = {8'h00, st_q.sre};
      end
    end else if (req.valid && req.write) begin
      // writes to live and event parts are dropped inside
      wr_vec[req.sel] = 1'h1; // RL6 RL9 RL13
    end else if (req.valid) begin
      st_d.rsp.data = rdata_vec[req.sel]; // RL3 RL19
      clr_vec[req.sel] = (req.part == PART_EVENT); // RL10
    end
    st_d.stb = stb_live; // RL16
    st_d.srq = |stb_rise; // RL21
    if (srst) begin
      st_d = '{rsp: '0, stb: 8'h00, sre: SRE_RST, srq: 1'h0};
    end
  end

  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rsp = st_q.rsp;
  assign status_byte = st_q.stb;
  assign service_request = st_q.srq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_answer;
    req.valid |=> rsp.valid;
  endproperty

  answer_next_a: assert property (p_answer) // RL19
    else $error("request not answered next cycle");

  answer_idle_a: assert property (!req.valid |=> !rsp.valid) // RL19
    else $error("answer without request");

  read_msb_a: assert property (rsp.valid |-> !rsp.data[15]) // RL3
    else $error("top bit of a part read as one");

  cal_bit_a: assert property (req.valid && !req.write && // RL4
    req.sel == SEL_OPER && req.part == PART_LIVE
    |=> rsp.data[OPER_CAL_BIT] == $past(cal_status, 2))
    else $error("calibration bit not at operation bit zero");

  live_ro_a: assert property (req.valid && req.write && // RL6
    req.sel == SEL_QUES && req.part == PART_LIVE ##1
    req.valid && !req.write && req.sel == SEL_QUES &&
    req.part == PART_LIVE |=> rsp.data[14:0] == $past(ques_status, 2))
    else $error("live part altered by write");

  event_clear_a: assert property (req.valid && !req.write && // RL10
    req.sel == SEL_SEV && req.part == PART_EVENT &&
    sev_status == $past(sev_status) ##1 req.valid && !req.write &&
    req.sel == SEL_SEV && req.part == PART_EVENT &&
    sev_status == $past(sev_status) |=> rsp.data == 16'h0000)
    else $error("event part not cleared by read");

  mav_follow_a: assert property (1'h1 |=> // RL18
    status_byte[STB_MAV] == $past(msg_available))
    else $error("message available bit stale");

  oper_chain_a: assert property (1'h1 |=> // RL14
    status_byte[STB_OPER] == $past(sum_vec[SEL_OPER]))
    else $error("operation sum not in status byte");

  sre_six_a: assert property (st_q.sre[STB_MSS] == 1'h0) // RL20
    else $error("enable bit six stored");

  mss_sum_a: assert property (1'h1 |=> status_byte[STB_MSS] == // RL17
    |(status_byte & $past(st_q.sre) & SRE_USED))
    else $error("summary bit six wrong");

  srq_edge_a: assert property (1'h1 |=> service_request == // RL21
    |(status_byte & ~$past(status_byte) & $past(st_q.sre) & SRE_USED))
    else $error("service request not tied to enabled rise");

  srq_pulse_c: cover property (!service_request ##1 service_request);
  mss_set_c: cover property ($rose(status_byte[STB_MSS]));
  event_read_c: cover property (req.valid && !req.write &&
    req.part == PART_EVENT ##1 rsp.data != 16'h0000);
  sre_write_c: cover property (req.valid && req.write &&
    req.sel == SEL_STB && req.part == PART_MASK);

endmodule : ssh_status_top

/* File: ssh_pkg.sv */
package ssh_pkg;

  // ****************************************************************
  // widths and selectors
  // ****************************************************************
  localparam int NUM_REGS = 3;
  typedef logic [14:0] ssh_bits_t;
  typedef logic [1:0] ssh_sel_t;
  typedef logic [2:0] ssh_part_t;

  localparam ssh_sel_t SEL_OPER = 2'h0;
  localparam ssh_sel_t SEL_QUES = 2'h1;
  localparam ssh_sel_t SEL_SEV = 2'h2;
  localparam ssh_sel_t SEL_STB = 2'h3;

  localparam ssh_part_t PART_LIVE = 3'h0;
  localparam ssh_part_t PART_RISE = 3'h1;
  localparam ssh_part_t PART_FALL = 3'h2;
  localparam ssh_part_t PART_EVENT = 3'h3;
  localparam ssh_part_t PART_MASK = 3'h4;

  // ****************************************************************
  // bit positions and reset values
  // ****************************************************************
  localparam int OPER_CAL_BIT = 0;
  localparam int STB_ERR = 2;
  localparam int STB_QUES = 3;
  localparam int STB_MAV = 4;
  localparam int STB_SEV = 5;
  localparam int STB_MSS = 6;
  localparam int STB_OPER = 7;
  localparam logic [7:0] SRE_USED = 8'hBF;
  localparam ssh_bits_t RISE_RST = 15'h7FFF;
  localparam ssh_bits_t FALL_RST = 15'h0000;
  localparam ssh_bits_t MASK_RST = 15'h0000;
  localparam ssh_bits_t EVENT_RST = 15'h0000;
  localparam logic [7:0] SRE_RST = 8'h00;

  // ****************************************************************
  // carriers and state
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic write;
    ssh_sel_t sel;
    ssh_part_t part;
    logic [15:0] wdata;
  } ssh_req_s;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } ssh_rsp_s;

  typedef struct packed {
    ssh_bits_t live;
    ssh_bits_t rise;
    ssh_bits_t fall;
    ssh_bits_t evt;
    ssh_bits_t mask;
    logic sum;
  } ssh_reg_s;

  typedef struct packed {
    ssh_rsp_s rsp;
    logic [7:0] stb;
    logic [7:0] sre;
    logic srq;
  } ssh_top_s;

endpackage : ssh_pkg

/* File: ssh_status_reg.sv */
`timescale 1ns/100ps
module ssh_status_reg (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // hardware status
  input wire ssh_pkg::ssh_bits_t live_in,
  // software access
  input wire logic wr_en,
  input wire ssh_pkg::ssh_part_t part,
  input wire ssh_pkg::ssh_bits_t wdata,
  input wire logic rd_clear,
  // results
  output logic [15:0] rdata,
  output logic sum
);
  import ssh_pkg::*;

  ssh_reg_s st_q;
  ssh_reg_s st_d;
  ssh_bits_t rise_hit;
  ssh_bits_t fall_hit;

  // ****************************************************************
  // edge filters and event latch
  // ****************************************************************
  assign rise_hit = live_in & ~st_q.live & st_q.rise; // RL7
  assign fall_hit = ~live_in & st_q.live & st_q.fall; // RL8

  always_comb begin
    st_d = st_q;
    st_d.live = live_in; // RL5
    if (wr_en && part == PART_RISE) begin
      st_d.rise = wdata; // RL9
    end else if (wr_en && part == PART_FALL) begin
      st_d.fall = wdata; // RL9
    end else if (wr_en && part == PART_MASK) begin
      st_d.mask = wdata; // RL13
    end
    // a new edge beats the clearing read
    st_d.evt = (rd_clear ? EVENT_RST : st_q.evt) | rise_hit | fall_hit; // RL22
    st_d.sum = |(st_q.evt & st_q.mask); // RL12
    if (srst) begin
      st_d = '{live: '0, rise: RISE_RST, fall: FALL_RST,
               evt: EVENT_RST, mask: MASK_RST, sum: 1'h0};
    end
  end

  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  always_comb begin
    case (part)
      PART_LIVE: rdata = {1'h0, st_q.live}; // RL3
      PART_RISE: rdata = {1'h0, st_q.rise};
      PART_FALL: rdata = {1'h0, st_q.fall};
      PART_EVENT: rdata = {1'h0, st_q.evt};
      PART_MASK: rdata = {1'h0, st_q.mask};
      default: rdata = 16'h0000;
    endcase
  end

  assign sum = st_q.sum;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  rise_latch_a: assert property (|rise_hit |=> // RL7
    ((st_q.evt & $past(rise_hit)) == $past(rise_hit)))
    else $error("rising edge not latched");
  fall_latch_a: assert property (|fall_hit |=> // RL8
    ((st_q.evt & $past(fall_hit)) == $past(fall_hit)))
    else $error("falling edge not latched");
  event_source_a: assert property (1'h1 |=> ((st_q.evt & // RL11
    ~$past(st_q.evt) & ~$past(rise_hit | fall_hit)) == 15'h0000))
    else $error("event set without filtered edge");
  read_clear_a: assert property (rd_clear && !(|rise_hit) && // RL10
    !(|fall_hit) |=> st_q.evt == 15'h0000)
    else $error("event part not cleared by read");
  // sum is registered from the event and mask parts one edge earlier
  sum_gate_a: assert property (1'h1 |=> // RL12
    sum == |($past(st_q.evt) & $past(st_q.mask)))
    else $error("sum bit wrong");
  live_track_a: assert property (1'h1 |=> st_q.live == $past(live_in)) // RL5
    else $error("live part not tracking hardware");

endmodule : ssh_status_reg

/* File: ssh_ctrl_model.sv */
`timescale 1ns/100ps
module ssh_ctrl_model (
  // clock
  input wire logic clock,
  // register link
  output ssh_pkg::ssh_req_s req,
  input wire ssh_pkg::ssh_rsp_s rsp
);
  import ssh_pkg::*;

  initial req = '0;

  // one request, held through the edge that takes it; call just after an
  // edge; with hold set the strobe stays up for a back-to-back follower
  task automatic xfer(input logic wr, input ssh_sel_t sel,
      input ssh_part_t part, input logic [15:0] wd, input logic hold,
      output ssh_rsp_s got);
    req = '{valid: 1'b1, write: wr, sel: sel, part: part, wdata: wd};
    @(posedge clock);
    #1;
    got = rsp;
    if (!hold) begin
      req.valid = 1'b0;
      // released data is scrambled so stale values cannot pass
      req.wdata = ~wd;
      @(posedge clock);
      #1;
    end
  endtask : xfer
endmodule : ssh_ctrl_model

/* File: tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
  import ssh_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  ssh_req_s req;
  ssh_rsp_s rsp;
  ssh_rsp_s got;
  logic cal_status = 1'b0;
  logic [14:1] oper_status = '0;
  ssh_bits_t ques_status = '0;
  ssh_bits_t sev_status = '0;
  logic err_queue_not_empty = 1'b0;
  logic msg_available = 1'b0;
  logic [7:0] status_byte;
  logic service_request;
  int bad_count = 0;
  int compares = 0;
  int srq_count = 0;
  int base;

  always #5 clock = ~clock;
  // the request is a one-cycle pulse, so count it on every edge
  always @(posedge clock) if (service_request === 1'b1) srq_count++;

  ssh_status_top u_dut (
    .clock(clock),
    .srst(srst),
    .req(req),
    .rsp(rsp),
    .cal_status(cal_status),
    .oper_status(oper_status),
    .ques_status(ques_status),
    .sev_status(sev_status),
    .err_queue_not_empty(err_queue_not_empty),
    .msg_available(msg_available),
    .status_byte(status_byte),
    .service_request(service_request)
  );

  ssh_ctrl_model u_ctrl (
    .clock(clock),
    .req(req),
    .rsp(rsp)
  );

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic wr(input ssh_sel_t s, input ssh_part_t p,
      input logic [15:0] d, input logic h = 1'b0);
    u_ctrl.xfer(1'b1, s, p, d, h, got);
    `CHK(got, 17'h10000)
  endtask : wr

  task automatic rd(input ssh_sel_t s, input ssh_part_t p,
      input logic [15:0] e, input logic h = 1'b0);
    u_ctrl.xfer(1'b0, s, p, 16'h0000, h, got);
    `CHK(got, {1'b1, e})
  endtask : rd

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic end_sim;
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    #20000;
    bad_count++;
    end_sim();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clock);
    #1;
    srst = 1'b0;
    for (int s = 0; s < 3; s++) begin
      rd(ssh_sel_t'(s), PART_RISE, 16'h7FFF);
      rd(ssh_sel_t'(s), PART_FALL, 16'h0000);
      rd(ssh_sel_t'(s), PART_EVENT, 16'h0000);
      rd(ssh_sel_t'(s), PART_MASK, 16'h0000);
      wr(ssh_sel_t'(s), PART_FALL, 16'hFFFF, 1'b1);
      rd(ssh_sel_t'(s), PART_FALL, 16'h7FFF);
      wr(ssh_sel_t'(s), PART_FALL, 16'h0000);
    end
    rd(SEL_STB, PART_MASK, 16'h0000);
    rd(SEL_STB, PART_LIVE, 16'h0000);
    rd(SEL_OPER, 3'h5, 16'h0000);
    // rising edges with the default filter
    ques_status = 15'h1234;
    step(4);
    rd(SEL_QUES, PART_LIVE, 16'h1234);
    wr(SEL_QUES, PART_LIVE, 16'h0000, 1'b1);
    rd(SEL_QUES, PART_LIVE, 16'h1234);
    rd(SEL_QUES, PART_EVENT, 16'h1234);
    rd(SEL_QUES, PART_EVENT, 16'h0000);
    // falling edges, only two positions let through
    wr(SEL_QUES, PART_RISE, 16'h0000);
    wr(SEL_QUES, PART_FALL, 16'h0030);
    ques_status = 15'h0000;
    step(4);
    rd(SEL_QUES, PART_EVENT, 16'h0030);
    rd(SEL_QUES, PART_RISE, 16'h0000);
    rd(SEL_QUES, PART_EVENT, 16'h0000);
    // sum bit up to the status byte and the request
    wr(SEL_QUES, PART_RISE, 16'h0001);
    wr(SEL_QUES, PART_MASK, 16'h0001);
    rd(SEL_QUES, PART_MASK, 16'h0001);
    wr(SEL_STB, PART_MASK, 16'hFFFF);
    rd(SEL_STB, PART_MASK, 16'h00BF);
    base = srq_count;
    ques_status = 15'h0001;
    step(5);
    `CHK(status_byte, 8'h48)
    `CHK(srq_count - base, 1)
    rd(SEL_STB, PART_LIVE, 16'h0048);
    rd(SEL_QUES, PART_EVENT, 16'h0001);
    step(4);
    `CHK(status_byte, 8'h00)
    // an event with its mask bit clear stays out of the sum
    sev_status = 15'h0001;
    step(5);
    `CHK(status_byte, 8'h00)
    rd(SEL_SEV, PART_EVENT, 16'h0001, 1'b1);
    rd(SEL_SEV, PART_EVENT, 16'h0000);
    // an edge on the clearing read's own edge must survive the clear
    sev_status = 15'h0003;
    rd(SEL_SEV, PART_EVENT, 16'h0000);
    rd(SEL_SEV, PART_EVENT, 16'h0002);
    // calibration status through the operation register
    base = srq_count;
    cal_status = 1'b1;
    oper_status = 14'h0002;
    step(4);
    rd(SEL_OPER, PART_LIVE, 16'h0005);
    wr(SEL_OPER, PART_MASK, 16'h0001);
    step(4);
    `CHK(status_byte, 8'hC0)
    err_queue_not_empty = 1'b1;
    msg_available = 1'b1;
    step(4);
    `CHK(status_byte, 8'hD4)
    `CHK(srq_count - base, 2)
    end_sim();
  end
endmodule : tb_top
